// ---- logic/adc_pd_params.svh ----
// Offsets, field positions, reset values and timing counts of the block
`ifndef ADC_PD_PARAMS_SVH
`define ADC_PD_PARAMS_SVH

`define REG_STATUS        8'h00
`define REG_CTRL_BYTE     8'h04
`define REG_SAMPLE        8'h08
`define REG_RESULT        8'h0C

`define ST_POWER_POS      0
`define ST_SHUTDOWN_PIN_POS       4
`define ST_BUSY_POS       7
`define ST_STROBE_POS     8
`define ST_EXT_MODE_POS   9

`define PD_LOW_POS        0
`define PD_HIGH_POS       1

`define CTRL_BITS         8
`define RESULT_BITS       12
`define OUT_SHIFT_BITS    16
`define START_ACCEPT_BIT  6

`define SAMPLE_RESET      12'h000
`define CTRL_BYTE_RESET   8'h00

`define MCLK_KHZ          25000
`define INT_CLK_FAST_KHZ  1800
`define INT_CLK_SLOW_KHZ  225
`define INT_DIV_FAST      (`MCLK_KHZ / `INT_CLK_FAST_KHZ)
`define INT_DIV_SLOW      (`MCLK_KHZ / `INT_CLK_SLOW_KHZ)

`define HOST_WAKE_INT_US     5
`define HOST_WAKE_EXTREF_US  2
`define HOST_WAKE_DUMMY_US   200
`define HOST_WAKE_EXTCAP_US  20000
`define HOST_WAKE_FILTER_US  9000

`endif

// ---- logic/adc_pd_pkg.sv ----
// Types shared by the power-down control block
package adc_pd_pkg;

  typedef enum logic [3:0] {
    PWR_ACTIVE  = 4'b0001,
    PWR_FAST_PD = 4'b0010,
    PWR_FULL_PD = 4'b0100,
    PWR_HW_SHUTDOWN_PIN = 4'b1000
  } power_type;

  typedef enum logic [2:0] {
    SHUTDOWN_PIN_LOW   = 3'b001,
    SHUTDOWN_PIN_HIGH  = 3'b010,
    SHUTDOWN_PIN_FLOAT = 3'b100
  } shutdown_pin_type;

  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_INT  = 3'b010,
    CONV_EXT  = 3'b100
  } conv_type;

endpackage

// ---- logic/adc_power_down_control.sv ----
// Power-down, clock-mode and serial control of the converter
// Function
// - Control byte low two bits pick software power-down unless pin low
// - Bits 00 full down, 01 fast down, 10 internal, 11 external clock
// - Serial interface keeps working in both software power-down states
// - Shutdown pin low shuts down fully, overriding the power bits
// - Software power-down waits for the running conversion to finish
// - Internal mode result stays readable after software power-down
// - First one on the data input is a start bit and wakes the part
// - High power bit set keeps the converter powered after conversion
// - Both power bits zero: one conversion, then power down again
// - Shutdown pin low abandons a running conversion at once
// - Floating shutdown pin runs the internal clock at 1.8MHz
// - Shutdown pin high runs the internal clock at 225kHz
// - Conversion starts on the clock fall after the eighth control bit
// - After reset: internal clock mode, strobe high, awaiting a start bit
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "adc_pd_params.svh"
module adc_power_down_control #(
  parameter int RESULT_BITS = `RESULT_BITS
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        csn,
  input  wire logic        din,
  input  wire logic        shutdownPin,
  input  wire logic        shutdownFloat,
  output logic             doutOut,
  output logic             doutOe,
  output logic             strobeOut,
  output logic             strobeOe
);

  // Synchronised pins and edges
  logic [4:0] pinsRaw;
  logic [4:0] pinsSync;
  logic       sclkS;
  logic       csnS;
  logic       dinS;
  logic       shdnLevelS;
  logic       shdnFloatS;
  logic       sclkD_r;
  logic       csnD_r;
  logic       sclkRise;
  logic       sclkFall;
  logic       csnRise;

  // Idle-high pins pass inverted so the reset state reads as idle
  assign pinsRaw = {shutdownFloat, ~shutdownPin, din, ~csn, sclk};

  pin_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pinIn  (pinsRaw),
    .pinOut (pinsSync)
  );

  assign sclkS      = pinsSync[0];
  assign csnS       = ~pinsSync[1];
  assign dinS       = pinsSync[2];
  assign shdnLevelS = ~pinsSync[3];
  assign shdnFloatS = pinsSync[4];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclkD_r <= 1'b0;
      csnD_r  <= 1'b1;
    end else begin
      sclkD_r <= sclkS;
      csnD_r  <= csnS;
    end
  end

  assign sclkRise = sclkS & ~sclkD_r;
  assign sclkFall = ~sclkS & sclkD_r;
  assign csnRise  = csnS & ~csnD_r;

  // Shutdown pin decode
  function automatic adc_pd_pkg::shutdown_pin_type decodeShdn(
    input logic floating,
    input logic level
  );
    if (floating) begin
      decodeShdn = adc_pd_pkg::SHUTDOWN_PIN_FLOAT;
    end else if (level) begin
      decodeShdn = adc_pd_pkg::SHUTDOWN_PIN_HIGH;
    end else begin
      decodeShdn = adc_pd_pkg::SHUTDOWN_PIN_LOW;
    end
  endfunction

  // One successive-approximation step
  function automatic logic [RESULT_BITS-1:0] sarDecide(
    input logic [RESULT_BITS-1:0] partial,
    input logic [RESULT_BITS-1:0] sample,
    input logic [3:0]             step
  );
    logic [RESULT_BITS-1:0] mask;
    mask = {1'b1, {(RESULT_BITS-1){1'b0}}} >> step;
    if (sample >= (partial | mask)) begin
      sarDecide = partial | mask;
    end else begin
      sarDecide = partial;
    end
  endfunction

  adc_pd_pkg::shutdown_pin_type shdnState;
  logic                 hwShutdown;

  assign shdnState  = decodeShdn(shdnFloatS, shdnLevelS);
  assign hwShutdown = (shdnState == adc_pd_pkg::SHUTDOWN_PIN_LOW);

  // State
  adc_pd_pkg::power_type  powerState_r;
  adc_pd_pkg::conv_type   convState_r;
  logic [3:0]             rxCount_r;
  logic [`CTRL_BITS-1:0]  rxByte_r;
  logic [`CTRL_BITS-1:0]  ctrlByte_r;
  logic                   extMode_r;
  logic                   csToggled_r;
  logic [3:0]             sarStep_r;
  logic [RESULT_BITS-1:0] sarValue_r;
  logic [RESULT_BITS-1:0] sampleHeld_r;
  logic [RESULT_BITS-1:0] sampleReg_r;
  logic [RESULT_BITS-1:0] result_r;
  logic [`OUT_SHIFT_BITS-1:0] outShift_r;
  logic [4:0]             outCount_r;

  logic                   startAllowed;
  logic                   startBit;
  logic                   launch;
  logic                   launchExt;
  logic                   stepEn;
  logic                   convDone;
  logic [RESULT_BITS-1:0] sarNext;
  logic [RESULT_BITS-1:0] stepMask;
  logic [1:0]             pdBits;

  int_clk_if intClk ();

  int_clk_div u_div (
    .mclk   (mclk),
    .resetn (resetn),
    .clk    (intClk.divider)
  );

  assign intClk.run     = (convState_r == adc_pd_pkg::CONV_INT);
  assign intClk.fastSel = (shdnState == adc_pd_pkg::SHUTDOWN_PIN_FLOAT);

  assign startAllowed = (convState_r == adc_pd_pkg::CONV_IDLE) |
                        (outCount_r >= 5'(`START_ACCEPT_BIT)) | csToggled_r;
  assign startBit = sclkRise & ~csnS & ~hwShutdown & (rxCount_r == 4'h0) &
                    dinS & startAllowed;
  assign launch   = sclkFall & ~csnS & ~hwShutdown &
                    (rxCount_r == 4'(`CTRL_BITS));
  assign pdBits   = {rxByte_r[`PD_HIGH_POS], rxByte_r[`PD_LOW_POS]};
  // Power-down codes keep the last clock mode
  assign launchExt = (pdBits == 2'b11) |
                     (~pdBits[1] & extMode_r);
  assign stepEn   = (convState_r == adc_pd_pkg::CONV_EXT) ? sclkFall :
                    ((convState_r == adc_pd_pkg::CONV_INT) & intClk.tick);
  assign sarNext  = sarDecide(sarValue_r, sampleHeld_r, sarStep_r);
  assign stepMask = {1'b1, {(RESULT_BITS-1){1'b0}}} >> sarStep_r;
  assign convDone = stepEn & ~launch & ~hwShutdown &
                    (sarStep_r == 4'(RESULT_BITS - 1));

  // Control byte reception
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxCount_r  <= 4'h0;
      rxByte_r   <= `CTRL_BYTE_RESET;
      ctrlByte_r <= `CTRL_BYTE_RESET;
    end else if (hwShutdown || csnS) begin
      rxCount_r <= 4'h0;
    end else if (launch) begin
      rxCount_r  <= 4'h0;
      ctrlByte_r <= rxByte_r;
    end else if (startBit) begin
      rxByte_r  <= {rxByte_r[`CTRL_BITS-2:0], 1'b1};
      rxCount_r <= 4'h1;
    end else if (sclkRise && rxCount_r != 4'h0 &&
                 rxCount_r < 4'(`CTRL_BITS)) begin
      rxByte_r  <= {rxByte_r[`CTRL_BITS-2:0], dinS};
      rxCount_r <= rxCount_r + 4'h1;
    end
  end

  // Chip select raised mid-conversion lets the next start bit through
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      csToggled_r <= 1'b0;
    end else if (csnRise &&
                 convState_r != adc_pd_pkg::CONV_IDLE) begin
      csToggled_r <= 1'b1;
    end else if (launch || convDone) begin
      csToggled_r <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      convState_r  <= adc_pd_pkg::CONV_IDLE;
      extMode_r    <= 1'b0;
      sarStep_r    <= 4'h0;
      sarValue_r   <= '0;
      sampleHeld_r <= '0;
      result_r     <= '0;
    end else if (hwShutdown) begin
      convState_r <= adc_pd_pkg::CONV_IDLE;
      extMode_r   <= 1'b0;
      sarStep_r   <= 4'h0;
    end else if (launch) begin
      convState_r  <= launchExt ? adc_pd_pkg::CONV_EXT :
                                  adc_pd_pkg::CONV_INT;
      extMode_r    <= launchExt;
      sarStep_r    <= 4'h0;
      sarValue_r   <= '0;
      sampleHeld_r <= sampleReg_r;
    end else if (stepEn) begin
      sarValue_r <= sarNext;
      sarStep_r  <= sarStep_r + 4'h1;
      if (convDone) begin
        convState_r <= adc_pd_pkg::CONV_IDLE;
        result_r    <= sarNext;
      end
    end
  end

  // Power state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      powerState_r <= adc_pd_pkg::PWR_ACTIVE;
    end else begin
      case (powerState_r)
        adc_pd_pkg::PWR_HW_SHUTDOWN_PIN: begin
          if (!hwShutdown) begin
            powerState_r <= adc_pd_pkg::PWR_ACTIVE;
          end
        end
        adc_pd_pkg::PWR_ACTIVE,
        adc_pd_pkg::PWR_FAST_PD,
        adc_pd_pkg::PWR_FULL_PD: begin
          if (hwShutdown) begin
            powerState_r <= adc_pd_pkg::PWR_HW_SHUTDOWN_PIN;
          end else if (startBit || launch) begin
            powerState_r <= adc_pd_pkg::PWR_ACTIVE;
          end else if (convDone) begin
            case ({ctrlByte_r[`PD_HIGH_POS], ctrlByte_r[`PD_LOW_POS]})
              2'b00: powerState_r <= adc_pd_pkg::PWR_FULL_PD;
              2'b01: powerState_r <= adc_pd_pkg::PWR_FAST_PD;
              default: powerState_r <= adc_pd_pkg::PWR_ACTIVE;
            endcase
          end
        end
        default: begin
          powerState_r <= adc_pd_pkg::PWR_ACTIVE;
        end
      endcase
    end
  end

  // Serial data out
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      doutOut    <= 1'b0;
      doutOe     <= 1'b0;
      outShift_r <= '0;
      outCount_r <= 5'h00;
    end else begin
      doutOe <= ~csnS & ~hwShutdown;
      if (hwShutdown) begin
        doutOut <= 1'b0;
      end else if (launch) begin
        doutOut    <= 1'b0;
        outShift_r <= '0;
        outCount_r <= 5'h00;
      end else if (stepEn && convState_r == adc_pd_pkg::CONV_EXT) begin
        doutOut    <= |(sarNext & stepMask);
        outCount_r <= outCount_r + 5'h01;
      end else if (convDone) begin
        // Result kept until shifted, whatever the power state
        outShift_r <= {sarNext, {(`OUT_SHIFT_BITS-RESULT_BITS){1'b0}}};
      end else if (sclkFall && !csnS &&
                   convState_r != adc_pd_pkg::CONV_INT) begin
        doutOut    <= outShift_r[`OUT_SHIFT_BITS-1];
        outShift_r <= {outShift_r[`OUT_SHIFT_BITS-2:0], 1'b0};
        if (outCount_r != 5'h1F) begin
          outCount_r <= outCount_r + 5'h01;
        end
      end
    end
  end

  // Conversion strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strobeOut <= 1'b1;
      strobeOe  <= 1'b1;
    end else if (hwShutdown) begin
      strobeOut <= 1'b1;
      strobeOe  <= 1'b0;
    end else begin
      strobeOe <= extMode_r ? ~csnS : 1'b1;
      if (launch) begin
        strobeOut <= launchExt;
      end else if (convState_r == adc_pd_pkg::CONV_INT) begin
        strobeOut <= convDone;
      end else if (extMode_r && sclkFall) begin
        strobeOut <= 1'b0;
      end else if (!extMode_r) begin
        strobeOut <= 1'b1;
      end
    end
  end

  // APB slave with one wait state
  logic        apbAccess;
  logic        mapped;
  logic [31:0] readValue;

  assign apbAccess = psel & penable & ~pready;

  always_comb begin
    readValue = 32'h0000_0000;
    mapped    = 1'b1;
    case (paddr)
      `REG_STATUS: begin
        readValue[`ST_POWER_POS +: 4] = powerState_r;
        readValue[`ST_SHUTDOWN_PIN_POS +: 3]  = shdnState;
        readValue[`ST_BUSY_POS]       =
          (convState_r != adc_pd_pkg::CONV_IDLE);
        readValue[`ST_STROBE_POS]     = strobeOut;
        readValue[`ST_EXT_MODE_POS]   = extMode_r;
      end
      `REG_CTRL_BYTE: readValue[`CTRL_BITS-1:0] = ctrlByte_r;
      `REG_SAMPLE:    readValue[RESULT_BITS-1:0] = sampleReg_r;
      `REG_RESULT:    readValue[RESULT_BITS-1:0] = result_r;
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess & ~mapped;
      prdata  <= (apbAccess && !pwrite) ? readValue : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sampleReg_r <= `SAMPLE_RESET;
    end else if (psel && penable && pready && pwrite &&
                 paddr == `REG_SAMPLE) begin
      sampleReg_r <= pwdata[RESULT_BITS-1:0];
    end
  end

endmodule

// ---- logic/int_clk_div.sv ----
// Internal conversion clock divider giving a one-cycle step enable
`timescale 1ns/1ps
`include "adc_pd_params.svh"
module int_clk_div #(
  parameter int FAST_DIV = `INT_DIV_FAST,
  parameter int SLOW_DIV = `INT_DIV_SLOW
) (
  input  wire logic  mclk,
  input  wire logic  resetn,
  int_clk_if.divider clk
);
  logic [7:0] count_r;
  logic [7:0] limit;

  assign limit = clk.fastSel ? 8'(FAST_DIV - 1) : 8'(SLOW_DIV - 1);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r  <= 8'h00;
      clk.tick <= 1'b0;
    end else if (!clk.run) begin
      count_r  <= 8'h00;
      clk.tick <= 1'b0;
    end else if (count_r >= limit) begin
      count_r  <= 8'h00;
      clk.tick <= 1'b1;
    end else begin
      count_r  <= count_r + 8'h01;
      clk.tick <= 1'b0;
    end
  end
endmodule

// ---- logic/int_clk_if.sv ----
// Carrier between the control logic and the internal clock divider
`timescale 1ns/1ps
interface int_clk_if;
  logic run;
  logic fastSel;
  logic tick;

  modport divider (input run, input fastSel, output tick);
  modport user    (output run, output fastSel, input tick);
endinterface

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= '0;
      pinOut   <= '0;
    end else begin
      stage1_r <= pinIn;
      pinOut   <= stage1_r;
    end
  end
endmodule

// ---- verification/adc_pd_checker_sva.sv ----
// Port assertions of the converter power-down control
`timescale 1ns/1ps
module adc_pd_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic csn,
  input wire logic sclk,
  input wire logic shutdownPin,
  input wire logic shutdownFloat,
  input wire logic doutOut,
  input wire logic doutOe,
  input wire logic strobeOut,
  input wire logic strobeOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  wire down = !shutdownPin && !shutdownFloat;
  wire live = !down;

  shutdown_pin_off_a: assert property (
    down[*5] |-> !strobeOe && !doutOe) else $error("pins on in shutdown");
  shutdown_pin_frozen_a: assert property (
    down[*6] |-> $stable(strobeOut)) else $error("strobe moves in shutdown");
  reset_strobe_a: assert property (
    $rose(resetn) |-> strobeOut && strobeOe) else $error("strobe low at reset");
  dout_on_a: assert property (
    (!csn && live)[*5] |-> doutOe) else $error("dout off while selected");
  dout_idle_a: assert property (
    csn[*5] |-> !doutOe) else $error("dout on while deselected");
  strobe_on_a: assert property (
    (!csn && live)[*5] |-> strobeOe) else $error("strobe off while running");
  dout_steady_a: assert property (
    sclk[*4] |-> $stable(doutOut)) else $error("dout moves with clock high");
  no_start_a: assert property (
    (csn && live)[*8] |-> !$fell(strobeOut)) else $error("start unselected");
  strobe_width_a: assert property (
    $rose(strobeOut) |=> strobeOut[*3]) else $error("strobe pulse short");

  cover property ($rose(strobeOut) && !csn);
  cover property (down[*6]);
  cover property ($fell(strobeOut) && live);
endmodule

bind adc_power_down_control adc_pd_checker chk (
  .mclk(mclk), .resetn(resetn), .csn(csn), .sclk(sclk),
  .shutdownPin(shutdownPin), .shutdownFloat(shutdownFloat),
  .doutOut(doutOut), .doutOe(doutOe), .strobeOut(strobeOut),
  .strobeOe(strobeOe));

// ---- verification/adc_power_down_control_test.sv ----
// Self-checking bench of the converter power-down control
`timescale 1ns/1ps
`include "adc_pd_params.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t: got %h want %h", $time, g, e); end end
module adc_power_down_control_test;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } note_type;
  localparam logic [3:0] ACT = adc_pd_pkg::PWR_ACTIVE;
  localparam logic [3:0] FPD = adc_pd_pkg::PWR_FAST_PD;
  localparam logic [3:0] FUL = adc_pd_pkg::PWR_FULL_PD;
  localparam logic [2:0] SHI = adc_pd_pkg::SHUTDOWN_PIN_HIGH;
  localparam logic [2:0] SFL = adc_pd_pkg::SHUTDOWN_PIN_FLOAT;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        sclk, csn, din, shutdownPin, shutdownFloat;
  logic        doutOut, doutOe, strobeOut, strobeOe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [11:0] smp, old;
  logic [15:0] rx;
  int          fails, checksDone, n, d;
  note_type    cur;
  note_type    notes[$];
  // Released data line shows the inverse of its last level
  wire         doutWire = doutOe ? doutOut : ~doutOut;

  adc_power_down_control dut (
    .mclk          (mclk),
    .resetn        (resetn),
    .paddr         (paddr),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .sclk          (sclk),
    .csn           (csn),
    .din           (din),
    .shutdownPin   (shutdownPin),
    .shutdownFloat (shutdownFloat),
    .doutOut       (doutOut),
    .doutOe        (doutOe),
    .strobeOut     (strobeOut),
    .strobeOe      (strobeOe)
  );
  // Host settling waits run on a shortened time base
  host_link #(
    .CYCLES_PER_US (1)
  ) host (
    .mclk (mclk),
    .dout (doutWire),
    .sclk (sclk),
    .csn  (csn),
    .din  (din)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] st(logic [3:0] p, logic [2:0] s,
                                     logic b, logic x);
    return (32'(p) << `ST_POWER_POS) | (32'(s) << `ST_SHUTDOWN_PIN_POS)
         | (32'(b) << `ST_STROBE_POS) | (32'(x) << `ST_EXT_MODE_POS);
  endfunction

  // Read expects d; write sends d
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    notes.push_back('{~wr, err, d});
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wr ? d : rnd();
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      conclude();
    end
  endtask

  task automatic waitStb(input logic lvl);
    for (n = 0; n < 3000 && strobeOut !== lvl; n++) @(posedge mclk);
    if (n == 3000) begin
      fails++;
      conclude();
    end
  endtask

  // Checks each bus answer against the oldest note
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      cur = notes.pop_front();
      `CHK(pslverr, cur.err)
      if (cur.rd) `CHK(prdata, cur.data)
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {resetn, shutdownPin, shutdownFloat} = 3'b011;
    seed = 32'h0001865C;
    fails = 0;
    checksDone = 0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    `CHK({strobeOut, strobeOe}, 2'b11)
    repeat (4) @(posedge mclk);
    apb(1'b1, `REG_STATUS, rnd(), 1'b0);
    apb(1'b0, `REG_STATUS, st(ACT, SFL, 1'b1, 1'b0), 1'b0);
    apb(1'b0, `REG_CTRL_BYTE, 32'h00000000, 1'b0);
    apb(1'b0, 8'h10, 32'h00000000, 1'b1);
    apb(1'b1, 8'h14, 32'h00000001, 1'b1);
    $display("register test done");
    smp = 12'(rnd());
    apb(1'b1, `REG_SAMPLE, {20'h0, smp}, 1'b0);
    apb(1'b0, `REG_SAMPLE, {20'h0, smp}, 1'b0);
    host.settle(host.wakeUs(1'b1, 1'b0, 1'b1, 1'b0));
    for (int k = 0; k < 2; k++) begin
      host.sel(1'b0);
      host.shift({8'h00, k ? 8'h80 : 8'h83}, 8, rx);
      host.shift(16'h0000, 16, rx);
      host.sel(1'b1);
      `CHK(rx, {1'b0, smp, 3'h0})
      apb(1'b0, `REG_STATUS, st(k ? FUL : ACT, SFL, 1'b0, 1'b1),
          1'b0);
    end
    apb(1'b0, `REG_RESULT, {20'h0, smp}, 1'b0);
    apb(1'b0, `REG_CTRL_BYTE, 32'h00000080, 1'b0);
    $display("external clock test done");
    for (int pd = 2; pd >= 0; pd--) begin
      shutdownFloat <= (pd != 2);
      shutdownPin <= (pd == 2);
      smp = 12'(rnd());
      apb(1'b1, `REG_SAMPLE, {20'h0, smp}, 1'b0);
      host.settle(host.wakeUs(1'b0, pd == 2, pd != 2,
                              pd == 0));
      host.sel(1'b0);
      host.shift({8'h00, 6'h20, 2'(pd)}, 16, rx);
      waitStb(1'b0);
      waitStb(1'b1);
      d = (pd == 2) ? `INT_DIV_SLOW : `INT_DIV_FAST;
      `CHK(n >= 11 * d && n <= 13 * d, 1'b1)
      apb(1'b0, `REG_STATUS, st(pd == 2 ? ACT : pd == 1 ? FPD : FUL,
          pd == 2 ? SHI : SFL, 1'b1, 1'b0), 1'b0);
      host.shift(16'h0000, 16, rx);
      host.sel(1'b1);
      `CHK(rx[14:3], smp)
      apb(1'b0, `REG_RESULT, {20'h0, smp}, 1'b0);
    end
    $display("internal clock test done");
    shutdownFloat <= 1'b0;
    shutdownPin <= 1'b1;
    old = smp;
    smp = 12'(rnd());
    apb(1'b1, `REG_SAMPLE, {20'h0, smp}, 1'b0);
    host.settle(host.wakeUs(1'b0, 1'b0, 1'b0, 1'b1));
    host.sel(1'b0);
    host.shift(16'h0082, 8, rx);
    waitStb(1'b0);
    repeat (100) @(posedge mclk);
    shutdownPin <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK({strobeOe, doutOe}, 2'b00)
    host.shift(16'h0083, 8, rx);
    repeat (1500) @(posedge mclk);
    apb(1'b0, `REG_RESULT, {20'h0, old}, 1'b0);
    shutdownPin <= 1'b1;
    host.sel(1'b1);
    repeat (6) @(posedge mclk);
    `CHK(strobeOut, 1'b1)
    apb(1'b0, `REG_STATUS, st(ACT, SHI, 1'b1, 1'b0), 1'b0);
    apb(1'b0, `REG_CTRL_BYTE, 32'h00000082, 1'b0);
    $display("shutdown test done");
    conclude();
  end
endmodule

// ---- verification/host_link.sv ----
// Host serial master model of the converter link
`timescale 1ns/1ps
`include "adc_pd_params.svh"
module host_link #(
  parameter int CYCLES_PER_US = 25
) (
  input  wire logic mclk,
  input  wire logic dout,
  output logic      sclk,
  output logic      csn,
  output logic      din
);
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    din = 1'b0;
  end
  // Deselected data line shows no stale level
  always @(posedge mclk) begin
    if (csn) begin
      din <= ~din;
    end
  end
  task automatic sel(input logic lvl);
    @(posedge mclk);
    csn <= lvl;
  endtask
  // Settling wait in microseconds before trusting results
  task automatic settle(input int us);
    repeat (us * CYCLES_PER_US) @(posedge mclk);
  endtask
  // Wait the host owes the converter before trusting a result
  function automatic int wakeUs(input logic extRef, input logic filtered,
                                input logic extComp, input logic fromFast);
    if (extRef) begin
      return `HOST_WAKE_EXTREF_US;
    end else if (filtered) begin
      return `HOST_WAKE_FILTER_US;
    end else if (!extComp) begin
      return `HOST_WAKE_INT_US;
    end else if (fromFast) begin
      return `HOST_WAKE_DUMMY_US;
    end
    return `HOST_WAKE_EXTCAP_US;
  endfunction
  // Data set in the low phase, read back in the high phase
  task automatic shift(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk);
      din <= tx[i];
      repeat (3) @(posedge mclk);
      sclk <= 1'b1;
      repeat (2) @(posedge mclk);
      rx[i] = dout;
      repeat (2) @(posedge mclk);
      sclk <= 1'b0;
    end
  endtask
endmodule
